// ===== verilog/spfa_pkg.sv
// Shared constants and types for the shared pin function arbiter
package spfa_pkg;

  // Port widths
  localparam int PORT_A_W = 6;
  localparam int PORT_B_W = 8;
  localparam int PIN_W = PORT_A_W + PORT_B_W;

  // Pad reset values: released, no pullup, low data
  localparam logic [PORT_A_W-1:0] PORT_A_OE_N_RST = 6'h3F;
  localparam logic [PORT_B_W-1:0] PORT_B_OE_N_RST = 8'hFF;
  localparam logic [PORT_A_W-1:0] PORT_A_ZERO = 6'h00;
  localparam logic [PORT_B_W-1:0] PORT_B_ZERO = 8'h00;

  // Reset value of synchroniser stages; an idle pin reads high through a pullup
  localparam logic [PIN_W-1:0] SYNC_RST = 14'h3FFF;

  // Cycles after reset release before any function may take a pin
  localparam logic [1:0] ARM_CYCLES = 2'h2;

  // Bit positions of the special-function lines within port A
  localparam int LINE_TIMER_EXT_CLOCK_IRQ = 2;
  localparam int LINE_RST = 3;
  localparam int LINE_CLK_OUT = 4;
  localparam int LINE_CLK_IN = 5;

  // Which function owns a pin
  typedef enum logic [3:0] {
    OWN_GPIO,
    OWN_ANALOG,
    OWN_TIMER_CH,
    OWN_TIMER_CLK,
    OWN_KEYPAD,
    OWN_EXT_IRQ,
    OWN_EXT_RST,
    OWN_CLK_OUT,
    OWN_CLK_IN
  } spfa_owner_t;

endpackage

// ===== verilog/spfa_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for asynchronous pin levels
module spfa_sync #(
  parameter int W = 14
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Raw and synchronised levels
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] meta_q;
  logic [W-1:0] stable_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= spfa_pkg::SYNC_RST[W-1:0];
      stable_q <= spfa_pkg::SYNC_RST[W-1:0];
    end
    else
    begin
      meta_q <= asyncIn;
      stable_q <= meta_q;
    end
  end

  assign syncOut = stable_q;

endmodule
`default_nettype wire

// ===== verilog/spfa_pad_bank.sv
`timescale 1ns/1ps
`default_nettype none
// Registered pad drivers for one port: data, active-low enable, pullup
module spfa_pad_bank #(
  parameter int W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Requested pad state from the arbiter
  input wire logic [W-1:0] driveReq,
  input wire logic [W-1:0] valueReq,
  input wire logic [W-1:0] pullReq,
  // Pad side
  output logic [W-1:0] padOut,
  output logic [W-1:0] padOeN,
  output logic [W-1:0] padPullup
);

  logic [W-1:0] out_q;
  logic [W-1:0] oeN_q;
  logic [W-1:0] pull_q;

  // Reset releases every pad; a driven pad never also pulls up
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out_q <= '0;
      oeN_q <= '1;
      pull_q <= '0;
    end
    else
    begin
      out_q <= valueReq & driveReq;
      oeN_q <= ~driveReq;
      pull_q <= pullReq & ~driveReq;
    end
  end

  assign padOut = out_q;
  assign padOeN = oeN_q;
  assign padPullup = pull_q;

endmodule
`default_nettype wire

// ===== verilog/spfa_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module spfa_arbiter (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Variant straps
  input wire logic adcPresent,
  input wire logic portBPresent,
  // Function enables
  input wire logic [3:0] analogEn,
  input wire logic [1:0] timerChEn,
  input wire logic timerClkEn,
  input wire logic [5:0] keypadEn,
  input wire logic extIrqEn,
  input wire logic extRstEn,
  input wire logic clockInPinEn,
  // Oscillator controls and clocks
  input wire logic xtalSel,
  input wire logic clockOutPinEnable,
  input wire logic xtalAmpOut,
  input wire logic intClkOut,
  // Timer channel drive
  input wire logic [1:0] timerChOut,
  input wire logic [1:0] timerChOutEn,
  // General-purpose data, direction and pullups
  input wire logic [5:0] gpioAOut,
  input wire logic [5:0] gpioADir,
  input wire logic [5:0] portAPullupEnable,
  input wire logic [7:0] gpioBOut,
  input wire logic [7:0] gpioBDir,
  input wire logic [7:0] portBPullupEnable,
  // Port A pads
  input wire logic [5:0] portAIn,
  output logic [5:0] portAOut,
  output logic [5:0] portAOeN,
  output logic [5:0] portAPullup,
  // Port B pads
  input wire logic [7:0] portBIn,
  output logic [7:0] portBOut,
  output logic [7:0] portBOeN,
  output logic [7:0] portBPullup,
  // Pin levels back to the functions
  output logic [5:0] gpioAIn,
  output logic [7:0] gpioBIn,
  output logic [5:0] keypadWakeIn,
  output logic [1:0] timerChIn,
  output logic timerClkIn,
  output logic extIrqIn_n,
  output logic extRstIn_n,
  output logic clockInPin,
  output logic [3:0] analogSel
);

  // First enabled candidate wins, GPIO is the fallback
  function automatic spfa_pkg::spfa_owner_t pick(
    input logic en0,
    input spfa_pkg::spfa_owner_t own0,
    input logic en1,
    input spfa_pkg::spfa_owner_t own1,
    input logic en2,
    input spfa_pkg::spfa_owner_t own2
  );
    spfa_pkg::spfa_owner_t res;
    res = spfa_pkg::OWN_GPIO;
    if (en0)
      res = own0;
    else if (en1)
      res = own1;
    else if (en2)
      res = own2;
    return res;
  endfunction

  // Reset release: functions wait until the arm counter expires
  logic [1:0] armCnt_q;
  logic [1:0] armCnt_d;
  logic armed;

  assign armed = (armCnt_q == spfa_pkg::ARM_CYCLES);
  assign armCnt_d = armed ? armCnt_q : armCnt_q + 2'h1;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      armCnt_q <= 2'h0;
    else
      armCnt_q <= armCnt_d;
  end

  // Straps are level inputs from outside; caught after release only
  logic [1:0] strapSync;

  spfa_sync #(
    .W(2)
  ) u_strap_sync (
    .clk(clk),
    .arst_n(arst_n),
    .asyncIn({adcPresent, portBPresent}),
    .syncOut(strapSync)
  );

  logic adcOk;
  logic portBOk;
  assign adcOk = strapSync[1];
  assign portBOk = strapSync[0];

  // Pin levels are asynchronous; two stages before any use
  logic [13:0] pinSync;

  spfa_sync #(
    .W(spfa_pkg::PIN_W)
  ) u_pin_sync (
    .clk(clk),
    .arst_n(arst_n),
    .asyncIn({portBIn, portAIn}),
    .syncOut(pinSync)
  );

  logic [5:0] pinA;
  logic [7:0] pinB;
  assign pinA = pinSync[5:0];
  assign pinB = pinSync[13:6];

  // Effective enables, gated by the arm window and, for analog only, by variant
  logic [3:0] anaOn;
  logic [1:0] tchOn;
  logic [5:0] kbdOn;
  logic tclkOn;
  logic irqOn;
  logic rstOn;
  logic oscOutOn;
  logic oscInOn;

  assign anaOn = analogEn & {4{adcOk & armed}};
  assign tchOn = timerChEn & {2{armed}};
  assign kbdOn = keypadEn & {6{armed}};
  assign tclkOn = timerClkEn & armed;
  assign irqOn = extIrqEn & armed;
  assign rstOn = extRstEn & armed;
  assign oscOutOn = (xtalSel | clockOutPinEnable) & armed;
  assign oscInOn = clockInPinEn & armed;

  // Owner of each port A line
  spfa_pkg::spfa_owner_t own [6];

  assign own[0] = pick(anaOn[0], spfa_pkg::OWN_ANALOG, tchOn[0], spfa_pkg::OWN_TIMER_CH,
    kbdOn[0], spfa_pkg::OWN_KEYPAD);
  assign own[1] = pick(anaOn[1], spfa_pkg::OWN_ANALOG, tchOn[1], spfa_pkg::OWN_TIMER_CH,
    kbdOn[1], spfa_pkg::OWN_KEYPAD);
  assign own[2] = pick(irqOn, spfa_pkg::OWN_EXT_IRQ, kbdOn[2], spfa_pkg::OWN_KEYPAD,
    tclkOn, spfa_pkg::OWN_TIMER_CLK);
  assign own[3] = pick(rstOn, spfa_pkg::OWN_EXT_RST, kbdOn[3], spfa_pkg::OWN_KEYPAD,
    1'b0, spfa_pkg::OWN_GPIO);
  assign own[4] = pick(oscOutOn, spfa_pkg::OWN_CLK_OUT, anaOn[2], spfa_pkg::OWN_ANALOG,
    kbdOn[4], spfa_pkg::OWN_KEYPAD);
  assign own[5] = pick(oscInOn, spfa_pkg::OWN_CLK_IN, anaOn[3], spfa_pkg::OWN_ANALOG,
    kbdOn[5], spfa_pkg::OWN_KEYPAD);

  // Clock source for line 4: crystal amplifier wins over internal clock
  logic clkOutVal;
  assign clkOutVal = xtalSel ? xtalAmpOut : intClkOut;

  // Port A drive requests per owner
  logic [5:0] aDrive;
  logic [5:0] aValue;
  logic [5:0] aPull;

  always_comb
  begin
    for (int i = 0; i < spfa_pkg::PORT_A_W; i++)
    begin
      aDrive[i] = 1'b0;
      aValue[i] = 1'b0;
      aPull[i] = portAPullupEnable[i];
      case (own[i])
        spfa_pkg::OWN_GPIO:
        begin
          aDrive[i] = gpioADir[i] & armed;
          aValue[i] = gpioAOut[i];
        end
        spfa_pkg::OWN_ANALOG:
          aPull[i] = 1'b0; // Pullup would bias the analog sample
        spfa_pkg::OWN_TIMER_CH:
        begin
          aDrive[i] = timerChOutEn[i % 2];
          aValue[i] = timerChOut[i % 2];
        end
        spfa_pkg::OWN_EXT_IRQ, spfa_pkg::OWN_EXT_RST:
          aPull[i] = 1'b1; // Internal pullup keeps the line inactive
        spfa_pkg::OWN_CLK_OUT:
        begin
          aDrive[i] = 1'b1;
          aValue[i] = clkOutVal;
        end
        spfa_pkg::OWN_CLK_IN:
          aPull[i] = 1'b0;
        default:
          aDrive[i] = 1'b0;
      endcase
    end
    // Line 2 is input only when left to GPIO
    if (own[spfa_pkg::LINE_TIMER_EXT_CLOCK_IRQ] == spfa_pkg::OWN_GPIO)
      aDrive[spfa_pkg::LINE_TIMER_EXT_CLOCK_IRQ] = 1'b0;
  end

  // Port B is pure GPIO and vanishes on the small package
  logic [7:0] bDrive;
  logic [7:0] bPull;
  assign bDrive = gpioBDir & {8{armed & portBOk}};
  assign bPull = portBPullupEnable & {8{portBOk & armed}};

  spfa_pad_bank #(
    .W(spfa_pkg::PORT_A_W)
  ) u_pad_a (
    .clk(clk),
    .arst_n(arst_n),
    .driveReq(aDrive),
    .valueReq(aValue),
    .pullReq(aPull),
    .padOut(portAOut),
    .padOeN(portAOeN),
    .padPullup(portAPullup)
  );

  spfa_pad_bank #(
    .W(spfa_pkg::PORT_B_W)
  ) u_pad_b (
    .clk(clk),
    .arst_n(arst_n),
    .driveReq(bDrive),
    .valueReq(gpioBOut),
    .pullReq(bPull),
    .padOut(portBOut),
    .padOeN(portBOeN),
    .padPullup(portBPullup)
  );

  // Returned levels: a function other than GPIO that does not own a pin sees its idle level
  logic [5:0] kbd_d;
  logic [1:0] tch_d;
  logic [3:0] ana_d;
  logic [5:0] gpioA_d;
  logic [7:0] gpioB_d;
  logic timer_ext_clock_d;
  logic irq_d;
  logic rst_d;
  logic cin_d;

  always_comb
  begin
    for (int i = 0; i < spfa_pkg::PORT_A_W; i++)
    begin
      kbd_d[i] = (own[i] == spfa_pkg::OWN_KEYPAD) ? pinA[i] : 1'b1;
      gpioA_d[i] = pinA[i]; // Readback always shows the pin
    end
    for (int j = 0; j < 2; j++)
      tch_d[j] = (own[j] == spfa_pkg::OWN_TIMER_CH) & pinA[j];
  end

  assign ana_d[0] = (own[0] == spfa_pkg::OWN_ANALOG);
  assign ana_d[1] = (own[1] == spfa_pkg::OWN_ANALOG);
  assign ana_d[2] = (own[4] == spfa_pkg::OWN_ANALOG);
  assign ana_d[3] = (own[5] == spfa_pkg::OWN_ANALOG);
  assign timer_ext_clock_d = (own[2] == spfa_pkg::OWN_TIMER_CLK) & pinA[2];
  assign irq_d = (own[2] == spfa_pkg::OWN_EXT_IRQ) ? pinA[2] : 1'b1;
  assign rst_d = (own[3] == spfa_pkg::OWN_EXT_RST) ? pinA[3] : 1'b1;
  assign cin_d = (own[5] == spfa_pkg::OWN_CLK_IN) & pinA[5];
  assign gpioB_d = pinB & {8{portBOk}};

  // Function-side outputs come from flops
  logic [5:0] kbd_q;
  logic [1:0] tch_q;
  logic [3:0] ana_q;
  logic [5:0] gpioA_q;
  logic [7:0] gpioB_q;
  logic timer_ext_clock_q;
  logic irq_q;
  logic rst_q;
  logic cin_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      kbd_q <= 6'h3F;
      tch_q <= 2'h0;
      ana_q <= 4'h0;
      gpioA_q <= spfa_pkg::PORT_A_ZERO;
      gpioB_q <= spfa_pkg::PORT_B_ZERO;
      timer_ext_clock_q <= 1'b0;
      irq_q <= 1'b1;
      rst_q <= 1'b1;
      cin_q <= 1'b0;
    end
    else
    begin
      kbd_q <= kbd_d;
      tch_q <= tch_d;
      ana_q <= ana_d;
      gpioA_q <= gpioA_d;
      gpioB_q <= gpioB_d;
      timer_ext_clock_q <= timer_ext_clock_d;
      irq_q <= irq_d;
      rst_q <= rst_d;
      cin_q <= cin_d;
    end
  end

  assign keypadWakeIn = kbd_q;
  assign timerChIn = tch_q;
  assign analogSel = ana_q;
  assign gpioAIn = gpioA_q;
  assign gpioBIn = gpioB_q;
  assign timerClkIn = timer_ext_clock_q;
  assign extIrqIn_n = irq_q;
  assign extRstIn_n = rst_q;
  assign clockInPin = cin_q;

endmodule
`default_nettype wire

// ===== verif/spfa_arbiter_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level ownership checks, bound beside the arbiter
module spfa_arbiter_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Straps and enables
  input wire logic adcPresent,
  input wire logic portBPresent,
  input wire logic [3:0] analogEn,
  input wire logic [1:0] timerChEn,
  input wire logic [5:0] keypadEn,
  input wire logic extIrqEn,
  input wire logic extRstEn,
  input wire logic xtalSel,
  input wire logic clockOutPinEnable,
  // Pads and function outputs
  input wire logic [5:0] portAIn,
  input wire logic [5:0] portAOeN,
  input wire logic [5:0] portAPullup,
  input wire logic [7:0] portBOeN,
  input wire logic [7:0] portBPullup,
  input wire logic [5:0] keypadWakeIn,
  input wire logic extIrqIn_n,
  input wire logic extRstIn_n,
  input wire logic [3:0] analogSel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Three edges of released pads after every reset, whatever is enabled
  rst_pins_in_a: assert property (
    $rose(arst_n) |-> (&portAOeN && &portBOeN) [*3])
    else $error("pin driven early after reset");
  line2_input_a: assert property (portAOeN[2])
    else $error("line 2 driven");
  // Straps take two sync edges, so allow a margin before judging
  portb_absent_a: assert property (
    !portBPresent [*4] |=> portBOeN == 8'hFF && portBPullup == 8'h00)
    else $error("absent port B active");
  analog_owns_a: assert property (
    (adcPresent && analogEn[0]) [*4] |=> analogSel[0] && portAOeN[0] && !portAPullup[0])
    else $error("analog not owning line 0");
  // Pin levels reach the functions three edges late
  keypad_follow_a: assert property (
    (!analogEn[1] && !timerChEn[1] && keypadEn[1]) [*6] |->
    keypadWakeIn[1] == $past(portAIn[1], 3))
    else $error("keypad line 1 wrong");
  irq_follow_a: assert property (
    extIrqEn [*6] |-> extIrqIn_n == $past(portAIn[2], 3) && keypadWakeIn[2])
    else $error("interrupt line wrong");
  rst_follow_a: assert property (
    extRstEn [*6] |-> extRstIn_n == $past(portAIn[3], 3) && portAOeN[3] && portAPullup[3])
    else $error("reset line wrong");
  clk_out_a: assert property (
    (xtalSel || clockOutPinEnable) [*4] |=> !portAOeN[4] && !analogSel[2])
    else $error("clock out not on line 4");
endmodule
bind spfa_arbiter spfa_arbiter_monitor i_spfa_arbiter_monitor (.*);
`default_nettype wire

// ===== verif/spfa_board.sv
`timescale 1ns/1ps
`default_nettype none
// Board around one port: optional external driver, else pullup, else floating
module spfa_board #(
  parameter int W = 6
) (
  // Clock for the floating pattern
  input wire logic clk,
  // Device pad side
  input wire logic [W-1:0] padOut,
  input wire logic [W-1:0] padOeN,
  input wire logic [W-1:0] padPullup,
  // External driver set by the bench
  input wire logic [W-1:0] extEn,
  input wire logic [W-1:0] extVal,
  // Resolved wire level
  output logic [W-1:0] pinLevel
);
  logic [W-1:0] float_q = '0;
  // A floating wire flips every cycle so a stale level never passes
  always @(posedge clk)
    float_q <= ~float_q;
  // Device drive, then board drive, then pullup, else float
  always_comb
    for (int i = 0; i < W; i++)
      pinLevel[i] = !padOeN[i] ? padOut[i] : extEn[i] ? extVal[i] :
        padPullup[i] ? 1'b1 : float_q[i];
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, arst_n, adcPresent, portBPresent, timerClkEn, extIrqEn, extRstEn;
  logic clockInPinEn, xtalSel, clockOutPinEnable, xtalAmpOut, intClkOut;
  logic timerClkIn, extIrqIn_n, extRstIn_n, clockInPin;
  logic [3:0] analogEn, analogSel;
  logic [1:0] timerChEn, timerChOut, timerChOutEn, timerChIn;
  logic [5:0] keypadEn, gpioAOut, gpioADir, portAPullupEnable, portAIn, portAOut;
  logic [5:0] portAOeN, portAPullup, gpioAIn, keypadWakeIn, extAEn, extAVal;
  logic [7:0] gpioBOut, gpioBDir, portBPullupEnable, portBIn, portBOut, portBOeN;
  logic [7:0] portBPullup, gpioBIn, extBEn, extBVal;
  int n_fail, samples_checked, cyc;

  spfa_arbiter i_spfa_arbiter (.*);
  spfa_board #(.W(6)) i_spfa_board (.clk, .padOut(portAOut), .padOeN(portAOeN),
    .padPullup(portAPullup), .extEn(extAEn), .extVal(extAVal), .pinLevel(portAIn));
  spfa_board #(.W(8)) i_spfa_board_b (.clk, .padOut(portBOut), .padOeN(portBOeN),
    .padPullup(portBPullup), .extEn(extBEn), .extVal(extBVal), .pinLevel(portBIn));

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Inputs always move 2 ns after an edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic final_report();
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Every line set as output, yet pads stay released through reset and arming
  task automatic t_reset();
    arst_n = 1'b0;
    wt(3);
    chk("oeA", portAOeN, 8'h3F);
    arst_n = 1'b1;
    wt(2);
    chk("oeB", portBOeN, 8'hFF);
    wt(3);
    chk("oeA", portAOeN, 8'h04);
    chk("outA", portAOut, 8'h3B);
    chk("outB", portBOut, 8'hA5);
  endtask

  // One timer line down its chain: analog, timer, keypad, GPIO
  task automatic t_timer(input int i);
    analogEn = 4'(1 << i);
    timerChEn = 2'(1 << i);
    timerChOutEn = 2'(1 << i);
    timerChOut = 2'(1 << i);
    keypadEn = 6'(1 << i);
    wt(5);
    chk("ana", {portAOeN[i], analogSel}, 8'(16 | (1 << i)));
    adcPresent = 1'b0;
    wt(5);
    chk("tmr", {portAOeN[i], portAOut[i]}, 8'h01);
    chk("tin", timerChIn[i], 8'h01);
    {analogEn, timerChEn} = 6'h00;
    adcPresent = 1'b1;
    extAEn = 6'(1 << i);
    extAVal = 6'h00;
    // Held seven edges so the line 1 keypad assertion sees its full window
    wt(7);
    chk("kbd", {portAOeN[i], keypadWakeIn[i]}, 8'h02);
    {keypadEn, extAEn} = 12'h000;
    wt(5);
    chk("gpio", {portAOeN[i], portAOut[i]}, 8'h01);
  endtask

  // Interrupt and reset outrank keypad and timer clock
  task automatic t_line23();
    {extIrqEn, extRstEn, timerClkEn} = 3'h7;
    keypadEn = 6'h0C;
    extAEn = 6'h0C;
    extAVal = 6'h04;
    // Held seven edges so the interrupt and reset assertions see their window
    wt(7);
    chk("irq", {extIrqIn_n, extRstIn_n, timerClkIn}, 8'h04);
    chk("kbd", keypadWakeIn[3:2], 8'h03);
    chk("rst", {portAOeN[3], portAPullup[3]}, 8'h03);
    {extIrqEn, extRstEn} = 2'h0;
    wt(5);
    chk("kbd", {keypadWakeIn[3:2], timerClkIn}, 8'h02);
    keypadEn = 6'h00;
    extAEn = 6'h04;
    wt(5);
    chk("timer_ext_clock", {timerClkIn, portAOeN[2], gpioAIn[2]}, 8'h07);
    {timerClkEn, extAEn} = 7'h00;
  endtask

  // Clock functions outrank analog on lines 4 and 5
  task automatic t_osc();
    {xtalSel, xtalAmpOut, clockInPinEn} = 3'h7;
    analogEn = 4'hC;
    extAEn = 6'h20;
    extAVal = 6'h20;
    wt(5);
    chk("osc", {portAOeN[4], portAOut[4], clockInPin}, 8'h03);
    chk("ana", analogSel, 8'h00);
    {xtalSel, clockOutPinEnable} = 2'h1;
    wt(5);
    chk("osc", {portAOeN[4], portAOut[4]}, 8'h00);
    {clockOutPinEnable, clockInPinEn, extAEn} = 8'h00;
    wt(5);
    chk("ana", {portAOeN[4], analogSel}, 8'h1C);
    analogEn = 4'h0;
  endtask

  // Released pins with pullups per bit, then port B on the small package
  task automatic t_pins();
    {gpioADir, gpioBDir} = 14'h0000;
    portAPullupEnable = 6'h2A;
    portBPullupEnable = 8'h5A;
    {extBEn, extBVal} = 16'hFF3C;
    wt(5);
    chk("puA", portAPullup, 8'h2A);
    chk("puB", {portBOeN ^ portBPullup}, 8'hA5);
    chk("inB", gpioBIn, 8'h3C);
    chk("inA", gpioAIn & 6'h2A, 8'h2A);
    gpioBDir = 8'hFF;
    portBPresent = 1'b0;
    wt(5);
    chk("oeB", portBOeN, 8'hFF);
    chk("puB", portBPullup, 8'h00);
    chk("inB", gpioBIn, 8'h00);
    portBPresent = 1'b1;
    extBEn = 8'h00;
    {gpioADir, portAPullupEnable, portBPullupEnable} = 20'hF_C000;
  endtask

  // Cut a hang short far beyond the planned run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      final_report();
    end
  end

  // Scenario sequence, ending with a second reset mid-run
  initial
  begin
    arst_n = 1'b0;
    {adcPresent, portBPresent} = 2'h3;
    {timerClkEn, extIrqEn, extRstEn, clockInPinEn} = 4'h0;
    {xtalSel, clockOutPinEnable, xtalAmpOut, intClkOut} = 4'h0;
    {analogEn, timerChEn, timerChOut, timerChOutEn, keypadEn} = 16'h0000;
    {gpioADir, gpioAOut} = 12'hFFF;
    {portAPullupEnable, extAEn, extAVal} = 18'h0_0000;
    {gpioBDir, gpioBOut} = 16'hFFA5;
    {portBPullupEnable, extBEn, extBVal} = 24'h00_0000;
    t_reset();
    t_timer(0);
    t_timer(1);
    t_line23();
    t_osc();
    t_pins();
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire
